// *** core/edrs_pkg.sv ***
// Package for the receive base and status register bank.
// Assumes a 32-bit APB master and a single REF_CLK domain.
package edrs_pkg;

  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_RX_BASE     = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_PERMIT      = 8'h08;
  localparam logic [7:0]  OFS_RX_REQUEST  = 8'h0C;
  localparam logic [7:0]  OFS_DMA_MODE    = 8'h10;
  localparam logic [7:0]  OFS_TXRX_MODE   = 8'h14;
  localparam logic [7:0]  OFS_TSU_STATUS  = 8'h18;

  // Status field positions
  localparam int          BIT_WB_DONE     = 30;
  localparam int          BIT_TX_ABORT    = 26;
  localparam int          BIT_RX_ABORT    = 25;
  localparam int          BIT_FRM_OVF     = 24;
  localparam int          BIT_MAC_SUM     = 22;

  // Bits software may clear by writing one
  localparam logic [31:0] STATUS_W1C_MASK = 32'h4700_0000;
  // Every implemented status bit
  localparam logic [31:0] STATUS_IMPL     = 32'h4740_0000;

  // Control fields
  localparam int          BIT_RX_REQUEST  = 0;
  localparam int          BIT_WB_SELECT   = 0;
  localparam int          BIT_TSU_ENABLE  = 1;
  localparam int          DLEN_LSB        = 4;
  localparam int          DLEN_W          = 2;

  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
  localparam logic [DLEN_W-1:0] DLEN_16   = 2'h0;
  localparam logic [DLEN_W-1:0] DLEN_32   = 2'h1;
  localparam logic [DLEN_W-1:0] DLEN_64   = 2'h2;

  // Hardware event strobes, one cycle each
  typedef struct packed {
    logic tx_writeback_done;
    logic tx_abort_flag;
    logic rx_abort_flag;
    logic rx_frame_counter_overflow;
  } edrs_evt_t;

  typedef enum logic [0:0] {
    RX_IDLE   = 1'b0,
    RX_ACTIVE = 1'b1
  } edrs_rx_state_t;

endpackage

// *** core/edrs_regs.sv ***
// Receive descriptor base, combined status, permission and request registers.
// Assumes event strobes and MAC summary level come from REF_CLK logic.
//
// Functional notes
// - 32-bit RW base register, zero at reset
// - Status bits 30 and 26-24 clear on write one only
// - Bit 22 read-only, follows MAC summary
// - Permission bit masks each status source
// - Channel status drives its own irq output
// - Second irq from timestamp unit status
// - Bit 30 sets on tx write-back done
// - Write-back flag only with select bit set
// - Bit 26 sets on tx abort
// - Bit 25 sets on rx abort
// - Bit 24 sets on frame counter overflow
// - Reserved bits 31, 29-27 read zero
// - Request one starts descriptor fetch, zero disables
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module edrs_regs
  import edrs_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input  wire logic              REF_CLK,
  input  wire logic              SRST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire edrs_evt_t         EVT,
  input  wire logic              MAC_SUMMARY,
  input  wire logic              TSU_EVENT,
  input  wire logic              RX_STOP,
  output logic                   RX_FETCH_START,
  output logic                   RX_ENABLE,
  output logic      [31:0]       RX_BASE,
  output logic      [DLEN_W-1:0] DESC_LEN,
  output logic                   IRQ_CHANNEL,
  output logic                   IRQ_TSU
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]    base_reg, base_next;
  logic [31:0]    status_reg, status_next;
  logic [31:0]    permit_reg, permit_next;
  logic [DLEN_W-1:0] dlen_reg, dlen_next;
  logic           wbsel_reg, wbsel_next;
  logic           tsu_reg, tsu_next;
  logic           tsu_mask_reg, tsu_mask_next;
  edrs_rx_state_t rx_reg, rx_next;
  logic           fetch_reg, fetch_next;
  logic [31:0]    rdata_reg, rdata_next;
  logic           err_reg, err_next;
  logic           irq_reg, irq_next;
  logic           irq_tsu_reg, irq_tsu_next;

  logic           acc;
  logic           wr;
  logic [31:0]    wmask;
  logic [31:0]    wdat;
  logic           hit;
  logic [31:0]    set_vec;

  // Zero-wait slave: every access completes in its first access cycle
  assign acc = PSEL & PENABLE;
  assign wr  = acc & PWRITE;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g+7:8*g] = {8{PSTRB[g]}};
    end
  endgenerate
  assign wdat = PWDATA & wmask;

  always_comb begin
    hit = 1'b1;
    case (PADDR)
      OFS_RX_BASE, OFS_STATUS, OFS_PERMIT, OFS_RX_REQUEST,
      OFS_DMA_MODE, OFS_TXRX_MODE, OFS_TSU_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status sources
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[BIT_WB_DONE]  = EVT.tx_writeback_done & wbsel_reg;
    set_vec[BIT_TX_ABORT] = EVT.tx_abort_flag;
    set_vec[BIT_RX_ABORT] = EVT.rx_abort_flag;
    set_vec[BIT_FRM_OVF]  = EVT.rx_frame_counter_overflow;
  end

  always_comb begin
    status_next = status_reg;
    if (wr && PADDR == OFS_STATUS) begin
      status_next = status_reg & ~(wdat & STATUS_W1C_MASK);
    end
    // Set wins over a same-cycle clear
    status_next = status_next | set_vec;
    status_next[BIT_MAC_SUM] = MAC_SUMMARY;
    status_next = status_next & STATUS_IMPL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and receive request
  always_comb begin
    base_next     = base_reg;
    permit_next   = permit_reg;
    dlen_next     = dlen_reg;
    wbsel_next    = wbsel_reg;
    tsu_mask_next = tsu_mask_reg;
    rx_next       = rx_reg;
    fetch_next    = 1'b0;
    tsu_next      = tsu_reg | TSU_EVENT;
    // Base is writable at any time; keeping it still while active is software's job
    if (wr && PADDR == OFS_RX_BASE) begin
      base_next = (base_reg & ~wmask) | wdat;
    end
    if (wr && PADDR == OFS_PERMIT) begin
      permit_next = ((permit_reg & ~wmask) | wdat) & STATUS_IMPL;
    end
    if (wr && PADDR == OFS_DMA_MODE && PSTRB[0]) begin
      dlen_next = PWDATA[DLEN_LSB +: DLEN_W];
    end
    if (wr && PADDR == OFS_TXRX_MODE && PSTRB[0]) begin
      wbsel_next    = PWDATA[BIT_WB_SELECT];
      tsu_mask_next = PWDATA[BIT_TSU_ENABLE];
    end
    if (wr && PADDR == OFS_TSU_STATUS && PSTRB[0] && PWDATA[0]) begin
      tsu_next = TSU_EVENT;
    end
    case (rx_reg)
      RX_IDLE: begin
        if (wr && PADDR == OFS_RX_REQUEST && PSTRB[0] && PWDATA[BIT_RX_REQUEST]) begin
          rx_next    = RX_ACTIVE;
          fetch_next = 1'b1;
        end
      end
      RX_ACTIVE: begin
        if (RX_STOP) begin
          rx_next = RX_IDLE;
        end else if (wr && PADDR == OFS_RX_REQUEST && PSTRB[0] &&
                     !PWDATA[BIT_RX_REQUEST]) begin
          rx_next = RX_IDLE;
        end
      end
      default: rx_next = RX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and interrupts
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = 1'b0;
    if (PSEL && !PENABLE) begin
      err_next = ~hit;
      case (PADDR)
        OFS_RX_BASE:    rdata_next = base_reg;
        OFS_STATUS:     rdata_next = status_reg & STATUS_IMPL;
        OFS_PERMIT:     rdata_next = permit_reg;
        OFS_RX_REQUEST: rdata_next = {31'h0, rx_reg == RX_ACTIVE};
        OFS_DMA_MODE:   rdata_next = {26'h0, dlen_reg, 4'h0};
        OFS_TXRX_MODE:  rdata_next = {30'h0, tsu_mask_reg, wbsel_reg};
        OFS_TSU_STATUS: rdata_next = {31'h0, tsu_reg};
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
    irq_next     = |(status_reg & permit_reg);
    irq_tsu_next = tsu_reg & tsu_mask_reg;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      base_reg     <= RESET_WORD;
      status_reg   <= RESET_WORD;
      permit_reg   <= RESET_WORD;
      dlen_reg     <= DLEN_16;
      wbsel_reg    <= 1'b0;
      tsu_reg      <= 1'b0;
      tsu_mask_reg <= 1'b0;
      rx_reg       <= RX_IDLE;
      fetch_reg    <= 1'b0;
      rdata_reg    <= RESET_WORD;
      err_reg      <= 1'b0;
      irq_reg      <= 1'b0;
      irq_tsu_reg  <= 1'b0;
    end else begin
      base_reg     <= base_next;
      status_reg   <= status_next;
      permit_reg   <= permit_next;
      dlen_reg     <= dlen_next;
      wbsel_reg    <= wbsel_next;
      tsu_reg      <= tsu_next;
      tsu_mask_reg <= tsu_mask_next;
      rx_reg       <= rx_next;
      fetch_reg    <= fetch_next;
      rdata_reg    <= rdata_next;
      err_reg      <= err_next;
      irq_reg      <= irq_next;
      irq_tsu_reg  <= irq_tsu_next;
    end
  end

  assign PRDATA         = rdata_reg;
  assign PREADY         = 1'b1;
  assign PSLVERR        = err_reg;
  assign RX_BASE        = base_reg;
  assign DESC_LEN       = dlen_reg;
  assign RX_ENABLE      = (rx_reg == RX_ACTIVE);
  assign RX_FETCH_START = fetch_reg;
  assign IRQ_CHANNEL    = irq_reg;
  assign IRQ_TSU        = irq_tsu_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Multi-step behaviours
  sequence s_tx_abort_clear;
    wr && PADDR == OFS_STATUS && PSTRB[3] && PWDATA[BIT_TX_ABORT] && !EVT.tx_abort_flag;
  endsequence
  // A permit write in the event cycle would move the irq, so it is excluded
  sequence s_ovf_permitted;
    EVT.rx_frame_counter_overflow && permit_reg[BIT_FRM_OVF] && !(wr && PADDR == OFS_PERMIT);
  endsequence
  sequence s_request_start;
    rx_reg == RX_IDLE && wr && PADDR == OFS_RX_REQUEST && PSTRB[0] && PWDATA[BIT_RX_REQUEST];
  endsequence
  sequence s_unmapped_setup;
    PSEL && !PENABLE && !hit;
  endsequence

  a_base_reset: assert property (@(posedge REF_CLK)
    $past(SRST) |-> base_reg == RESET_WORD)
    else $error("base not zero after reset");
  a_base_write: assert property (@(posedge REF_CLK) disable iff (SRST)
    wr && PADDR == OFS_RX_BASE && PSTRB == 4'hF |=> RX_BASE == $past(PWDATA))
    else $error("base write not taken");
  a_w1c_clear: assert property (@(posedge REF_CLK) disable iff (SRST)
    s_tx_abort_clear |=> !status_reg[BIT_TX_ABORT])
    else $error("tx abort not cleared by write one");
  a_sticky_bit: assert property (@(posedge REF_CLK) disable iff (SRST)
    status_reg[BIT_RX_ABORT] && !(wr && PADDR == OFS_STATUS && PSTRB[3] && PWDATA[BIT_RX_ABORT])
    |=> status_reg[BIT_RX_ABORT])
    else $error("rx abort lost without clear");
  a_summary_follow: assert property (@(posedge REF_CLK) disable iff (SRST)
    ##1 status_reg[BIT_MAC_SUM] == $past(MAC_SUMMARY))
    else $error("summary flag not tracking mac");
  a_mask_irq: assert property (@(posedge REF_CLK) disable iff (SRST)
    (status_reg & permit_reg) == 32'h0 |=> !IRQ_CHANNEL)
    else $error("masked source raised irq");
  a_irq_level: assert property (@(posedge REF_CLK) disable iff (SRST)
    (status_reg & permit_reg) != 32'h0 |=> IRQ_CHANNEL)
    else $error("unmasked source without irq");
  a_irq_raise: assert property (@(posedge REF_CLK) disable iff (SRST)
    s_ovf_permitted |-> ##2 IRQ_CHANNEL)
    else $error("channel irq missing");
  a_tsu_irq: assert property (@(posedge REF_CLK) disable iff (SRST)
    tsu_reg && tsu_mask_reg |=> IRQ_TSU)
    else $error("tsu irq missing");
  a_tsu_mask: assert property (@(posedge REF_CLK) disable iff (SRST)
    !(tsu_reg && tsu_mask_reg) |=> !IRQ_TSU)
    else $error("tsu irq without source");
  a_wb_gate: assert property (@(posedge REF_CLK) disable iff (SRST)
    !status_reg[BIT_WB_DONE] && !wbsel_reg |=> !status_reg[BIT_WB_DONE])
    else $error("write-back flag set while disabled");
  a_wb_set: assert property (@(posedge REF_CLK) disable iff (SRST)
    EVT.tx_writeback_done && wbsel_reg |=> status_reg[BIT_WB_DONE])
    else $error("write-back flag not set");
  a_abort_sets: assert property (@(posedge REF_CLK) disable iff (SRST)
    EVT.tx_abort_flag |=> status_reg[BIT_TX_ABORT])
    else $error("tx abort not set");
  a_rxabort_set: assert property (@(posedge REF_CLK) disable iff (SRST)
    EVT.rx_abort_flag |=> status_reg[BIT_RX_ABORT])
    else $error("rx abort not set");
  a_overflow_set: assert property (@(posedge REF_CLK) disable iff (SRST)
    EVT.rx_frame_counter_overflow |=> status_reg[BIT_FRM_OVF])
    else $error("overflow not set");
  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (SRST)
    (status_reg & ~STATUS_IMPL) == 32'h0)
    else $error("reserved status bit set");
  a_fetch_start: assert property (@(posedge REF_CLK) disable iff (SRST)
    RX_FETCH_START |-> RX_ENABLE && !$past(RX_ENABLE))
    else $error("fetch without request rise");
  a_fetch_pulse: assert property (@(posedge REF_CLK) disable iff (SRST)
    s_request_start |=> RX_FETCH_START && RX_ENABLE)
    else $error("request write did not start fetch");
  a_rx_stop: assert property (@(posedge REF_CLK) disable iff (SRST)
    RX_ENABLE && RX_STOP |=> !RX_ENABLE)
    else $error("stop did not drop request");
  a_unmapped_err: assert property (@(posedge REF_CLK) disable iff (SRST)
    s_unmapped_setup |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access without error");

endmodule

// *** test/edrs_tb.sv ***
// Self-checking bench for the receive base and status register bank.
// Assumes edrs_pkg and edrs_regs are compiled first; the bench drives APB and events.
`timescale 1ns/1ns
module testbench;
  import edrs_pkg::*;
  logic              clk;
  logic              srst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  edrs_evt_t         evt;
  logic              mac_sum;
  logic              tsu_evt;
  logic              rx_stop;
  logic              fetch;
  logic              rx_en;
  logic [31:0]       rx_base;
  logic [DLEN_W-1:0] desc_len;
  logic              irq_ch;
  logic              irq_tsu;
  int                err_count;
  int                n_checks;
  int                fetch_cnt = 0;
  logic [31:0]       rdata;
  logic              rerr;
  logic [31:0]       base_val [3];
  ////////////////////////////////////////////////////////////////////////////////
  edrs_regs #(.CHANNEL(0)) u_dut (
    .REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EVT(evt), .MAC_SUMMARY(mac_sum), .TSU_EVENT(tsu_evt),
    .RX_STOP(rx_stop), .RX_FETCH_START(fetch), .RX_ENABLE(rx_en), .RX_BASE(rx_base),
    .DESC_LEN(desc_len), .IRQ_CHANNEL(irq_ch), .IRQ_TSU(irq_tsu)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counts start pulses so a missed or doubled pulse shows
  always @(posedge clk) begin
    if (fetch === 1'b1) fetch_cnt <= fetch_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Request held until PREADY seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready wait", 32'h0, 32'h1);
      test_done();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rdata, exp);
  endtask
  // Bits: rx_stop, tsu_evt, then event struct
  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    {rx_stop, tsu_evt, evt} <= v;
    @(posedge clk);
    {rx_stop, tsu_evt, evt} <= 6'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic tdone(input string name);
    repeat (2) @(posedge clk);
    $display("Test %s finished", name);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {err_count, n_checks} = '0;
    {psel, penable, pwrite, mac_sum, tsu_evt, rx_stop} = 6'h00;
    {paddr, pwdata, evt} = '0;
    pstrb = 4'hF;
    srst = 1'b1;
    base_val = '{32'h1234_5670, 32'h89AB_CDE0, 32'hFEDC_BA40};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd("base reset", OFS_RX_BASE, 32'h0000_0000);
    chk("base err", {31'h0, rerr}, 32'h0);
    rd("status reset", OFS_STATUS, 32'h0000_0000);
    tdone("reset");
    // Base only rewritten while reception is off, aligned to each length
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_DMA_MODE, 32'(i) << DLEN_LSB);
      apb(1'b1, OFS_RX_BASE, base_val[i]);
      rd("base", OFS_RX_BASE, base_val[i]);
      chk("base pin", rx_base, base_val[i]);
      chk("dl pin", {30'h0, desc_len}, 32'(i));
    end
    tdone("base");
    apb(1'b1, OFS_RX_REQUEST, 32'h0000_0001);
    apb(1'b1, OFS_RX_REQUEST, 32'h0000_0001);
    tdone("req");
    chk("fetch count", 32'(fetch_cnt), 32'h1);
    chk("rx enable", {31'h0, rx_en}, 32'h1);
    pulse(6'h20);
    rd("req after stop", OFS_RX_REQUEST, 32'h0000_0000);
    apb(1'b1, OFS_RX_REQUEST, 32'h0000_0001);
    apb(1'b1, OFS_RX_REQUEST, 32'h0000_0000);
    tdone("request");
    chk("fetch count 2", 32'(fetch_cnt), 32'h2);
    chk("rx disable", {31'h0, rx_en}, 32'h0);
    // Write-back select off: that event must not register
    pulse(6'h0F);
    rd("events", OFS_STATUS, 32'h0700_0000);
    tdone("events");
    rd("sticky", OFS_STATUS, 32'h0700_0000);
    chk("irq masked", {31'h0, irq_ch}, 32'h0);
    apb(1'b1, OFS_PERMIT, 32'h0100_0000);
    tdone("permit");
    chk("irq unmasked", {31'h0, irq_ch}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h0000_0000);
    rd("write zero", OFS_STATUS, 32'h0700_0000);
    pstrb <= 4'h7;
    apb(1'b1, OFS_STATUS, 32'h0700_0000);
    pstrb <= 4'hF;
    rd("lane off", OFS_STATUS, 32'h0700_0000);
    apb(1'b1, OFS_STATUS, 32'h0600_0000);
    rd("partial clear", OFS_STATUS, 32'h0100_0000);
    apb(1'b1, OFS_STATUS, 32'h0100_0000);
    rd("all clear", OFS_STATUS, 32'h0000_0000);
    tdone("clear");
    chk("irq cleared", {31'h0, irq_ch}, 32'h0);
    pulse(6'h01);
    chk("irq overflow", {31'h0, irq_ch}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h0100_0000);
    rd("ovf clear", OFS_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_TXRX_MODE, 32'h0000_0001);
    apb(1'b1, OFS_PERMIT, 32'h4000_0000);
    pulse(6'h08);
    rd("writeback", OFS_STATUS, 32'h4000_0000);
    tdone("writeback");
    chk("irq writeback", {31'h0, irq_ch}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h4000_0000);
    rd("wb clear", OFS_STATUS, 32'h0000_0000);
    // Summary flag follows its source only
    mac_sum <= 1'b1;
    apb(1'b1, OFS_PERMIT, 32'h0040_0000);
    apb(1'b1, OFS_STATUS, 32'h0040_0000);
    rd("summary", OFS_STATUS, 32'h0040_0000);
    tdone("summary");
    chk("irq summary", {31'h0, irq_ch}, 32'h1);
    mac_sum <= 1'b0;
    rd("summary off", OFS_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_STATUS, 32'h0040_0000);
    rd("summary write", OFS_STATUS, 32'h0000_0000);
    tdone("summary off");
    chk("irq summary off", {31'h0, irq_ch}, 32'h0);
    apb(1'b1, OFS_TXRX_MODE, 32'h0000_0002);
    pulse(6'h10);
    rd("tsu status", OFS_TSU_STATUS, 32'h0000_0001);
    chk("irq tsu", {31'h0, irq_tsu}, 32'h1);
    chk("irq ch quiet", {31'h0, irq_ch}, 32'h0);
    apb(1'b1, OFS_TSU_STATUS, 32'h0000_0001);
    tdone("tsu");
    chk("irq tsu off", {31'h0, irq_tsu}, 32'h0);
    rd("unmapped", 8'h20, 32'h0000_0000);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    tdone("unmapped");
    test_done();
  end
endmodule
